/* verilog/camera_link_video_rx.sv */
// camera link receive block: pixel qualification, camera controls, serial channel
`timescale 1ns/1ns


// ********************************************************************
// dual-clock fifo with gray pointers
// ********************************************************************
module pixel_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             i_wr_clk,
	input  wire logic             i_wr_rst,
	input  wire logic             i_wr_valid,
	output logic                  o_wr_ready,
	input  wire logic [WIDTH-1:0] i_wr_data,
	input  wire logic             i_rd_clk,
	input  wire logic             i_rd_rst,
	output logic                  o_rd_valid,
	input  wire logic             i_rd_ready,
	output logic      [WIDTH-1:0] o_rd_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_bin;
	logic [AW:0]      wr_gray;
	logic [AW:0]      rd_bin;
	logic [AW:0]      rd_gray;
	logic [AW:0]      rd_gray_meta;
	logic [AW:0]      rd_gray_wr;
	logic [AW:0]      wr_gray_meta;
	logic [AW:0]      wr_gray_rd;
	logic [AW:0]      next_wr_bin;
	logic [AW:0]      next_rd_bin;
	logic             push;
	logic             pop;

	// full compares against the far pointer with its top two bits inverted
	assign o_wr_ready  = (wr_gray != {~rd_gray_wr[AW:AW-1], rd_gray_wr[AW-2:0]});
	assign o_rd_valid  = (rd_gray != wr_gray_rd);
	assign push        = i_wr_valid & o_wr_ready;
	assign pop         = o_rd_valid & i_rd_ready;
	assign next_wr_bin = wr_bin + (AW+1)'(push);
	assign next_rd_bin = rd_bin + (AW+1)'(pop);
	assign o_rd_data   = mem[rd_bin[AW-1:0]];

	always_ff @(posedge i_wr_clk) begin
		if (push) begin
			mem[wr_bin[AW-1:0]] <= i_wr_data;
		end
	end

	always_ff @(posedge i_wr_clk) begin
		if (i_wr_rst) begin
			wr_bin  <= '0;
			wr_gray <= '0;
		end else begin
			wr_bin  <= next_wr_bin;
			wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
		end
	end

	always_ff @(posedge i_wr_clk) begin
		if (i_wr_rst) begin
			rd_gray_meta <= '0;
			rd_gray_wr   <= '0;
		end else begin
			rd_gray_meta <= rd_gray;
			rd_gray_wr   <= rd_gray_meta;
		end
	end

	always_ff @(posedge i_rd_clk) begin
		if (i_rd_rst) begin
			rd_bin  <= '0;
			rd_gray <= '0;
		end else begin
			rd_bin  <= next_rd_bin;
			rd_gray <= next_rd_bin ^ (next_rd_bin >> 1);
		end
	end

	always_ff @(posedge i_rd_clk) begin
		if (i_rd_rst) begin
			wr_gray_meta <= '0;
			wr_gray_rd   <= '0;
		end else begin
			wr_gray_meta <= wr_gray;
			wr_gray_rd   <= wr_gray_meta;
		end
	end

endmodule // pixel_fifo

// ********************************************************************
// receiver top
// ********************************************************************
module camera_link_video_rx (
	input  wire logic                                i_clk,
	input  wire logic                                i_rst,
	input  wire logic                                i_pix_clk,
	input  wire cl_rx_pkg::enables_t [cl_rx_pkg::NUM_LINKS-1:0] i_link_enables,
	input  wire logic [cl_rx_pkg::DATA_W-1:0]        i_port_data,
	input  wire cl_rx_pkg::link_cfg_t                i_link_cfg,
	input  wire logic                                i_dval_used,
	output cl_rx_pkg::pixel_word_t                   o_pixel,
	output logic                                     o_pixel_valid,
	input  wire logic                                i_pixel_ready,
	output logic                                     o_overflow,
	input  wire logic                                i_overflow_clear,
	input  wire logic                                i_exposure_sync_pulse,
	input  wire logic                                i_pixel_reset_control,
	input  wire logic                                i_scan_forward,
	output logic [3:0]                               o_camera_control,
	input  wire logic                                i_ser_to_grabber,
	output logic                                     o_ser_to_camera,
	input  wire logic [7:0]                          i_tx_data,
	input  wire logic                                i_tx_valid,
	output logic                                     o_tx_ready,
	output logic [7:0]                               o_rx_data,
	output logic                                     o_rx_valid,
	output logic                                     o_rx_frame_err
);

	// ****************************************************************
	// pixel-clock domain: reset and config crossings
	// ****************************************************************
	logic                       rst_pix_meta;
	logic                       rst_pix;
	cl_rx_pkg::link_cfg_t       cfg_meta;
	cl_rx_pkg::link_cfg_t       cfg_pix;
	logic                       dval_used_meta;
	logic                       dval_used_pix;

	// config is a quasi-static level; change it only between frames
	always_ff @(posedge i_pix_clk) begin
		rst_pix_meta   <= i_rst;
		rst_pix        <= rst_pix_meta;
		cfg_meta       <= i_link_cfg;
		cfg_pix        <= cfg_meta;
		dval_used_meta <= i_dval_used;
		dval_used_pix  <= dval_used_meta;
	end

	// ****************************************************************
	// pixel-clock domain: qualification and framing
	// ****************************************************************
	cl_rx_pkg::enables_t        en;
	logic                       fval_d;
	logic                       lval_d;
	logic                       fval_rise;
	logic                       lval_rise;
	logic                       accept;
	logic                       wr_ready;
	logic                       written;
	logic                       sof_pending;
	logic                       sol_pending;
	logic [cl_rx_pkg::IDX_W-1:0] pix_count;
	logic [cl_rx_pkg::DATA_W-1:0] port_mask;
	cl_rx_pkg::pixel_word_t     wr_word;
	logic                       ovf_toggle;

	// qualification follows the first link; the others carry copies
	assign en        = i_link_enables[0];
	// spare enable bit deliberately left unread
	assign fval_rise = en.fval & ~fval_d;
	assign lval_rise = en.lval & ~lval_d;
	assign accept    = en.fval & en.lval & (en.dval | ~dval_used_pix);
	assign written   = accept & wr_ready;

	// ports beyond the configuration are masked so their content never leaks
	always_comb begin
		port_mask = '0;
		for (int p = 0; p < cl_rx_pkg::NUM_PORTS; p++) begin
			unique case (cfg_pix)
				cl_rx_pkg::CFG_BASE: begin
					if (p < cl_rx_pkg::PORTS_BASE) begin
						port_mask[p*cl_rx_pkg::PORT_W +: cl_rx_pkg::PORT_W] = 8'hFF;
					end
				end
				cl_rx_pkg::CFG_MEDIUM: begin
					if (p < cl_rx_pkg::PORTS_MEDIUM) begin
						port_mask[p*cl_rx_pkg::PORT_W +: cl_rx_pkg::PORT_W] = 8'hFF;
					end
				end
				default: begin
					if (p < cl_rx_pkg::PORTS_FULL) begin
						port_mask[p*cl_rx_pkg::PORT_W +: cl_rx_pkg::PORT_W] = 8'hFF;
					end
				end
			endcase
		end
	end

	// three 8-bit ports plus four enables fit the 28-bit link budget
	assign wr_word.data  = i_port_data & port_mask;
	assign wr_word.sof   = sof_pending | fval_rise;
	assign wr_word.sol   = sol_pending | lval_rise;
	assign wr_word.index = lval_rise ? '0 : pix_count;

	always_ff @(posedge i_pix_clk) begin
		if (rst_pix) begin
			fval_d <= 1'b0;
			lval_d <= 1'b0;
		end else begin
			fval_d <= en.fval;
			lval_d <= en.lval;
		end
	end

	// a start mark survives a dropped word and rides on the next stored one
	always_ff @(posedge i_pix_clk) begin
		if (rst_pix) begin
			sof_pending <= 1'b0;
		end else if (written) begin
			sof_pending <= 1'b0;
		end else if (fval_rise) begin
			sof_pending <= 1'b1;
		end
	end

	always_ff @(posedge i_pix_clk) begin
		if (rst_pix) begin
			sol_pending <= 1'b0;
		end else if (written) begin
			sol_pending <= 1'b0;
		end else if (lval_rise) begin
			sol_pending <= 1'b1;
		end
	end

	// counts accepted pixels, dropped ones included, so positions stay true
	always_ff @(posedge i_pix_clk) begin
		if (rst_pix) begin
			pix_count <= '0;
		end else if (lval_rise) begin
			pix_count <= accept ? cl_rx_pkg::IDX_W'(1) : '0;
		end else if (accept) begin
			pix_count <= pix_count + cl_rx_pkg::IDX_W'(1);
		end
	end

	// the camera cannot be stalled, so a full fifo drops and reports it
	always_ff @(posedge i_pix_clk) begin
		if (rst_pix) begin
			ovf_toggle <= 1'b0;
		end else if (accept & ~wr_ready) begin
			ovf_toggle <= ~ovf_toggle;
		end
	end

	// ****************************************************************
	// buffer between the domains
	// ****************************************************************
	pixel_fifo #(
		.WIDTH (cl_rx_pkg::WORD_W),
		.DEPTH (cl_rx_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_wr_clk   (i_pix_clk),
		.i_wr_rst   (rst_pix),
		.i_wr_valid (accept),
		.o_wr_ready (wr_ready),
		.i_wr_data  (wr_word),
		.i_rd_clk   (i_clk),
		.i_rd_rst   (i_rst),
		.o_rd_valid (o_pixel_valid),
		.i_rd_ready (i_pixel_ready),
		.o_rd_data  (o_pixel)
	);

	// ****************************************************************
	// system domain: overflow report
	// ****************************************************************
	logic ovf_meta;
	logic ovf_sync;
	logic ovf_seen;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ovf_meta <= 1'b0;
			ovf_sync <= 1'b0;
			ovf_seen <= 1'b0;
		end else begin
			ovf_meta <= ovf_toggle;
			ovf_sync <= ovf_meta;
			ovf_seen <= ovf_sync;
		end
	end

	// a new drop in the clearing cycle keeps the flag set
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_overflow <= 1'b0;
		end else if (ovf_sync ^ ovf_seen) begin
			o_overflow <= 1'b1;
		end else if (i_overflow_clear) begin
			o_overflow <= 1'b0;
		end
	end

	// ****************************************************************
	// camera controls
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_camera_control <= cl_rx_pkg::CC_RESET;
		end else begin
			o_camera_control <= {1'b1, i_scan_forward,
				i_pixel_reset_control, i_exposure_sync_pulse};
		end
	end

	// ****************************************************************
	// serial transmit toward the camera
	// ****************************************************************
	cl_rx_pkg::ser_state_t               tx_state;
	logic [cl_rx_pkg::BIT_CNT_W-1:0]     tx_cnt;
	logic [2:0]                          tx_bit;
	logic [7:0]                          tx_shift;

	// no handshake lines exist; the ready is only the local byte interface
	assign o_tx_ready = (tx_state == cl_rx_pkg::SER_IDLE);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_state        <= cl_rx_pkg::SER_IDLE;
			tx_cnt          <= '0;
			tx_bit          <= '0;
			tx_shift        <= '0;
			o_ser_to_camera <= cl_rx_pkg::LINE_IDLE;
		end else begin
			unique case (tx_state)
				cl_rx_pkg::SER_IDLE: begin
					o_ser_to_camera <= cl_rx_pkg::LINE_IDLE;
					if (i_tx_valid) begin
						tx_shift        <= i_tx_data;
						tx_cnt          <= cl_rx_pkg::BIT_LOAD;
						o_ser_to_camera <= 1'b0;
						tx_state        <= cl_rx_pkg::SER_START;
					end
				end
				cl_rx_pkg::SER_START: begin
					if (tx_cnt == '0) begin
						tx_cnt          <= cl_rx_pkg::BIT_LOAD;
						tx_bit          <= '0;
						o_ser_to_camera <= tx_shift[0];
						tx_shift        <= {1'b0, tx_shift[7:1]};
						tx_state        <= cl_rx_pkg::SER_DATA;
					end else begin
						tx_cnt <= tx_cnt - 1'b1;
					end
				end
				cl_rx_pkg::SER_DATA: begin
					if (tx_cnt == '0) begin
						tx_cnt <= cl_rx_pkg::BIT_LOAD;
						if (tx_bit == cl_rx_pkg::LAST_BIT) begin
							// no parity: stop bit follows data directly
							o_ser_to_camera <= 1'b1;
							tx_state        <= cl_rx_pkg::SER_STOP;
						end else begin
							tx_bit          <= tx_bit + 1'b1;
							o_ser_to_camera <= tx_shift[0];
							tx_shift        <= {1'b0, tx_shift[7:1]};
						end
					end else begin
						tx_cnt <= tx_cnt - 1'b1;
					end
				end
				cl_rx_pkg::SER_STOP: begin
					if (tx_cnt == '0) begin
						tx_state <= cl_rx_pkg::SER_IDLE;
					end else begin
						tx_cnt <= tx_cnt - 1'b1;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// serial receive from the camera
	// ****************************************************************
	cl_rx_pkg::ser_state_t               rx_state;
	logic [cl_rx_pkg::BIT_CNT_W-1:0]     rx_cnt;
	logic [2:0]                          rx_bit;
	logic [7:0]                          rx_shift;
	logic                                rx_meta;
	logic                                rx_line;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_meta <= cl_rx_pkg::LINE_IDLE;
			rx_line <= cl_rx_pkg::LINE_IDLE;
		end else begin
			rx_meta <= i_ser_to_grabber;
			rx_line <= rx_meta;
		end
	end

	// sampling at mid-bit tolerates a few percent of rate mismatch
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_state       <= cl_rx_pkg::SER_IDLE;
			rx_cnt         <= '0;
			rx_bit         <= '0;
			rx_shift       <= '0;
			o_rx_data      <= 8'h00;
			o_rx_valid     <= 1'b0;
			o_rx_frame_err <= 1'b0;
		end else begin
			o_rx_valid <= 1'b0;
			unique case (rx_state)
				cl_rx_pkg::SER_IDLE: begin
					if (!rx_line) begin
						rx_cnt   <= cl_rx_pkg::HALF_LOAD;
						rx_state <= cl_rx_pkg::SER_START;
					end
				end
				cl_rx_pkg::SER_START: begin
					if (rx_cnt == '0) begin
						rx_cnt   <= cl_rx_pkg::BIT_LOAD;
						rx_bit   <= '0;
						// a glitch shorter than half a bit is not a start
						rx_state <= rx_line ? cl_rx_pkg::SER_IDLE : cl_rx_pkg::SER_DATA;
					end else begin
						rx_cnt <= rx_cnt - 1'b1;
					end
				end
				cl_rx_pkg::SER_DATA: begin
					if (rx_cnt == '0) begin
						rx_cnt   <= cl_rx_pkg::BIT_LOAD;
						rx_shift <= {rx_line, rx_shift[7:1]};
						rx_bit   <= rx_bit + 1'b1;
						if (rx_bit == cl_rx_pkg::LAST_BIT) begin
							rx_state <= cl_rx_pkg::SER_STOP;
						end
					end else begin
						rx_cnt <= rx_cnt - 1'b1;
					end
				end
				cl_rx_pkg::SER_STOP: begin
					if (rx_cnt == '0) begin
						o_rx_data      <= rx_shift;
						o_rx_valid     <= 1'b1;
						o_rx_frame_err <= ~rx_line;
						rx_state       <= cl_rx_pkg::SER_IDLE;
					end else begin
						rx_cnt <= rx_cnt - 1'b1;
					end
				end
			endcase
		end
	end

endmodule // camera_link_video_rx

/* verilog/cl_rx_pkg.sv */
// shared constants, types and state codes for the camera link receiver
package cl_rx_pkg;

	// ****************************************************************
	// link geometry
	// ****************************************************************
	localparam int NUM_LINKS     = 3;
	localparam int NUM_PORTS     = 8;
	localparam int PORT_W        = 8;
	localparam int LINK_BITS     = 28;
	localparam int PORTS_PER_LNK = 3;
	localparam int PORTS_BASE    = 3;
	localparam int PORTS_MEDIUM  = 6;
	localparam int PORTS_FULL    = 8;
	localparam int DATA_W        = NUM_PORTS * PORT_W;
	localparam int IDX_W         = 16;
	localparam int FIFO_DEPTH    = 32;

	// ****************************************************************
	// serial channel timing
	// ****************************************************************
	localparam int SYS_CLK_HZ  = 20_000_000;
	localparam int BAUD_RATE   = 9600;
	localparam int BIT_CYCLES  = SYS_CLK_HZ / BAUD_RATE;
	localparam int BIT_CNT_W   = 12;
	localparam logic [BIT_CNT_W-1:0] BIT_LOAD  = BIT_CNT_W'(BIT_CYCLES - 1);
	localparam logic [BIT_CNT_W-1:0] HALF_LOAD = BIT_CNT_W'(BIT_CYCLES / 2 - 1);
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [3:0] CC_RESET   = 4'h8;
	localparam logic       LINE_IDLE  = 1'b1;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		CFG_BASE   = 2'h0,
		CFG_MEDIUM = 2'h1,
		CFG_FULL   = 2'h2
	} link_cfg_t;

	typedef struct packed {
		logic spare;
		logic dval;
		logic lval;
		logic fval;
	} enables_t;

	typedef struct packed {
		logic              sof;
		logic              sol;
		logic [IDX_W-1:0]  index;
		logic [DATA_W-1:0] data;
	} pixel_word_t;

	localparam int WORD_W = $bits(pixel_word_t);

	typedef enum logic [3:0] {
		SER_IDLE  = 4'h1,
		SER_START = 4'h2,
		SER_DATA  = 4'h4,
		SER_STOP  = 4'h8
	} ser_state_t;

endpackage

/* sim/cl_rx_checker.sv */
// port-level assertions for the camera link receiver
`timescale 1ns/1ns
module cl_rx_checker (
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	input wire cl_rx_pkg::link_cfg_t   i_link_cfg,
	input wire cl_rx_pkg::pixel_word_t o_pixel,
	input wire logic                   o_pixel_valid,
	input wire logic                   i_pixel_ready,
	input wire logic                   o_overflow,
	input wire logic                   i_overflow_clear,
	input wire logic                   i_exposure_sync_pulse,
	input wire logic                   i_pixel_reset_control,
	input wire logic                   i_scan_forward,
	input wire logic [3:0]             o_camera_control,
	input wire logic                   o_ser_to_camera,
	input wire logic                   i_tx_valid,
	input wire logic                   o_tx_ready,
	input wire logic                   o_rx_valid
);
	// ****************************************************************
	// checks
	// ****************************************************************
	// ten bit times, a little slack for the take-edge offset
	localparam int FRAME_LO = 20828;
	localparam int FRAME_HI = 20834;
	logic [15:0] busy_cnt;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	always_ff @(posedge i_clk) begin
		if (i_rst || o_tx_ready)
			busy_cnt <= 16'h0;
		else
			busy_cnt <= busy_cnt + 16'h1;
	end
	sequence s_take;
		i_tx_valid && o_tx_ready;
	endsequence
	sequence s_start_low;
		(!o_ser_to_camera && !o_tx_ready) [*8];
	endsequence
	property p_tx_start;
		s_take |=> s_start_low;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start bit after take");
	property p_tx_idle;
		o_tx_ready |-> o_ser_to_camera;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("serial out low while idle");
	property p_tx_len;
		$rose(o_tx_ready) |-> busy_cnt >= FRAME_LO && busy_cnt <= FRAME_HI && $past(o_ser_to_camera);
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("serial character length wrong");
	property p_rx_pulse;
		o_rx_valid |=> !o_rx_valid;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("receive valid longer than one cycle");
	property p_cc_map;
		!$past(i_rst) |-> o_camera_control == {1'b1, $past(i_scan_forward),
			$past(i_pixel_reset_control), $past(i_exposure_sync_pulse)};
	endproperty
	a_cc_map: assert property (p_cc_map) else $error("camera control mapping wrong");
	property p_cc_high;
		o_camera_control[3];
	endproperty
	a_cc_high: assert property (p_cc_high) else $error("fourth control not high");
	property p_hold;
		o_pixel_valid && !i_pixel_ready |=> o_pixel_valid && $stable(o_pixel);
	endproperty
	a_hold: assert property (p_hold) else $error("pixel head changed without pop");
	property p_sol_idx;
		o_pixel_valid && o_pixel.sol |-> o_pixel.index == 16'h0 && (o_pixel.sol || !o_pixel.sof);
	endproperty
	a_sol_idx: assert property (p_sol_idx) else $error("line start index not zero");
	property p_sof_sol;
		o_pixel_valid && o_pixel.sof |-> o_pixel.sol;
	endproperty
	a_sof_sol: assert property (p_sof_sol) else $error("frame start without line start");
	property p_base_mask;
		o_pixel_valid && i_link_cfg == cl_rx_pkg::CFG_BASE |-> o_pixel.data[63:24] == 40'h0;
	endproperty
	a_base_mask: assert property (p_base_mask) else $error("base word has upper ports");
	property p_med_mask;
		o_pixel_valid && i_link_cfg == cl_rx_pkg::CFG_MEDIUM |-> o_pixel.data[63:48] == 16'h0;
	endproperty
	a_med_mask: assert property (p_med_mask) else $error("medium word has upper ports");
	property p_ovf_sticky;
		o_overflow && !i_overflow_clear |=> o_overflow;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped by itself");
endmodule // cl_rx_checker

bind camera_link_video_rx cl_rx_checker chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_link_cfg(i_link_cfg), .o_pixel(o_pixel), .o_pixel_valid(o_pixel_valid),
	.i_pixel_ready(i_pixel_ready), .o_overflow(o_overflow), .i_overflow_clear(i_overflow_clear),
	.i_exposure_sync_pulse(i_exposure_sync_pulse), .i_pixel_reset_control(i_pixel_reset_control),
	.i_scan_forward(i_scan_forward), .o_camera_control(o_camera_control),
	.o_ser_to_camera(o_ser_to_camera), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
	.o_rx_valid(o_rx_valid));

/* sim/camera_model.sv */
// camera-side model: enables, pixel ports and serial line toward the grabber
`timescale 1ns/1ns
module camera_model (
	input  wire logic                      i_pix_clk,
	output cl_rx_pkg::enables_t [2:0]      o_enables,
	output logic [cl_rx_pkg::DATA_W-1:0]   o_data,
	output logic                           o_ser
);
	// ****************************************************************
	// behaviour
	// ****************************************************************
	localparam int BIT_NS = 2083 * 50;
	logic in_frame;
	initial begin
		o_enables = '0;
		o_data = '0;
		o_ser = 1'b1;
		in_frame = 1'b0;
	end
	// idle bus alternates each clock between the last pixel and its inverse
	always @(posedge i_pix_clk) if (!in_frame && !o_enables[0].fval) o_data <= ~o_data;
	task automatic beat(input logic f, l, d, input logic [63:0] mask, inout integer s);
		cl_rx_pkg::enables_t e;
		e = {1'($random(s)), d, l, f};
		@(posedge i_pix_clk);
		o_enables <= {3{e}};
		o_data <= ({$random(s), $random(s)} & mask) | ~mask;
	endtask
	task automatic send_frame(input int lines, pix, input bit gaps, input logic [63:0] mask,
		inout integer s);
		int j;
		logic d;
		in_frame = 1'b1;
		beat(1'b1, 1'b0, 1'b0, mask, s);
		for (int i = 0; i < lines; i++) begin
			j = 0;
			while (j < pix) begin
				d = !(gaps && ($random(s) & 3) == 0);
				beat(1'b1, 1'b1, d, mask, s);
				if (d)
					j++;
			end
			beat(1'b1, 1'b0, 1'b0, mask, s);
			beat(1'b1, 1'b0, 1'b0, mask, s);
		end
		beat(1'b0, 1'b0, 1'b0, mask, s);
		in_frame = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] b, input logic stop);
		o_ser = 1'b0;
		#BIT_NS;
		for (int i = 0; i < 8; i++) begin
			o_ser = b[i];
			#BIT_NS;
		end
		o_ser = stop;
		#BIT_NS;
		o_ser = 1'b1;
	endtask
endmodule // camera_model

/* sim/testbench.sv */
// self-checking bench for the camera link receiver
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
	// ****************************************************************
	// stimulus, reference model and checks
	// ****************************************************************
	logic i_clk, i_rst, i_pix_clk, i_dval_used, i_pixel_ready, i_overflow_clear, stall;
	logic i_exposure_sync_pulse, i_pixel_reset_control, i_scan_forward, i_tx_valid;
	logic o_pixel_valid, o_overflow, o_ser_to_camera, o_tx_ready, o_rx_valid, o_rx_frame_err;
	logic i_ser_to_grabber, pf, pl, sofp, solp, err_seen;
	logic [3:0] o_camera_control;
	logic [7:0] i_tx_data, o_rx_data, tb, rb, got, rx_seen;
	logic [cl_rx_pkg::DATA_W-1:0] i_port_data;
	cl_rx_pkg::enables_t [2:0] i_link_enables;
	cl_rx_pkg::link_cfg_t i_link_cfg;
	cl_rx_pkg::pixel_word_t o_pixel, w, exp_q[$];
	integer err_total, n_tests, seed, k, n, n2, m, idx, rx_cnt;
	camera_link_video_rx dut (.i_clk(i_clk), .i_rst(i_rst), .i_pix_clk(i_pix_clk),
		.i_link_enables(i_link_enables), .i_port_data(i_port_data), .i_link_cfg(i_link_cfg),
		.i_dval_used(i_dval_used), .o_pixel(o_pixel), .o_pixel_valid(o_pixel_valid),
		.i_pixel_ready(i_pixel_ready), .o_overflow(o_overflow), .i_overflow_clear(i_overflow_clear),
		.i_exposure_sync_pulse(i_exposure_sync_pulse), .i_pixel_reset_control(i_pixel_reset_control),
		.i_scan_forward(i_scan_forward), .o_camera_control(o_camera_control),
		.i_ser_to_grabber(i_ser_to_grabber), .o_ser_to_camera(o_ser_to_camera),
		.i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
		.o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .o_rx_frame_err(o_rx_frame_err));
	camera_model cam (.i_pix_clk(i_pix_clk), .o_enables(i_link_enables), .o_data(i_port_data),
		.o_ser(i_ser_to_grabber));
	function automatic logic [63:0] port_mask(input logic [1:0] c);
		return (c == 2'h0) ? 64'h0000000000FFFFFF : (c == 2'h1) ? 64'h0000FFFFFFFFFFFF : '1;
	endfunction
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic drain;
		for (n = 0; n < 3000 && (exp_q.size() != 0 || o_pixel_valid !== 1'b0); n++) @(negedge i_clk);
		`CHK("words_left", 0, exp_q.size())
		`CHK("valid_idle", 1'b0, o_pixel_valid)
	endtask
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// even 12 ns offset keeps the two clocks' rising edges apart
	initial begin
		i_pix_clk = 1'b0;
		#12;
		forever #32 i_pix_clk = ~i_pix_clk;
	end
	always @(posedge i_clk) i_pixel_ready <= !stall && $random(seed) % 2 != 0;
	always @(posedge i_pix_clk) begin
		if (i_link_enables[0].fval && !pf)
			sofp = 1'b1;
		if (i_link_enables[0].lval && !pl) begin
			solp = 1'b1;
			idx = 0;
		end
		if (i_link_enables[0].fval && i_link_enables[0].lval &&
			(i_link_enables[0].dval || !i_dval_used)) begin
			w = {sofp, solp, 16'(idx), i_port_data & port_mask(i_link_cfg)};
			if (exp_q.size() < cl_rx_pkg::FIFO_DEPTH)
				exp_q.push_back(w);
			sofp = 1'b0;
			solp = 1'b0;
			idx++;
		end
		pf = i_link_enables[0].fval;
		pl = i_link_enables[0].lval;
	end
	always @(posedge i_clk) if (!i_rst && o_pixel_valid === 1'b1 && i_pixel_ready) begin
		`CHK("pixel", exp_q.size() ? exp_q[0] : 'x, o_pixel)
		if (exp_q.size())
			void'(exp_q.pop_front());
	end
	always @(negedge i_clk) if (o_rx_valid === 1'b1) begin
		rx_seen = o_rx_data;
		err_seen = o_rx_frame_err;
		rx_cnt++;
	end
	initial begin
		repeat (100000) @(posedge i_clk);
		err_total++;
		$display("BAD watchdog exp finish got hang");
		complete_run;
	end
	initial begin
		seed = 32'hC428B8D5;
		{err_total, n_tests, rx_cnt, idx} = '0;
		{pf, pl, sofp, solp, stall} = 5'h01;
		{i_dval_used, i_pixel_ready, i_overflow_clear, i_tx_valid} = '0;
		{i_exposure_sync_pulse, i_pixel_reset_control, i_scan_forward} = '0;
		i_tx_data = '0;
		i_link_cfg = cl_rx_pkg::CFG_BASE;
		i_rst = 1'b1;
		repeat (6) @(posedge i_clk);
		`CHK("cc_reset", 4'h8, o_camera_control)
		`CHK("ser_idle", 1'b1, o_ser_to_camera)
		`CHK("ovf_reset", 1'b0, o_overflow)
		i_rst <= 1'b0;
		for (k = 0; k < 8; k++) begin
			@(posedge i_clk);
			{i_scan_forward, i_pixel_reset_control, i_exposure_sync_pulse} <= k[2:0];
			repeat (2) @(posedge i_clk);
			#1 `CHK("cc", {1'b1, k[2:0]}, o_camera_control)
		end
		$display("test camera controls done");
		stall = 1'b0;
		for (k = 0; k < 4; k++) begin
			@(posedge i_clk);
			i_link_cfg <= cl_rx_pkg::link_cfg_t'(k[1:0]);
			i_dval_used <= k[0];
			repeat (10) @(posedge i_clk);
			cam.send_frame(2, 5 + k, 1'b1, port_mask(k[1:0]), seed);
			drain;
			$display("test frame config %0d done", k);
		end
		`CHK("ovf_none", 1'b0, o_overflow)
		stall = 1'b1;
		cam.send_frame(1, 40, 1'b0, '1, seed);
		repeat (10) @(posedge i_clk);
		#1 `CHK("ovf_set", 1'b1, o_overflow)
		@(posedge i_clk) i_overflow_clear <= 1'b1;
		@(posedge i_clk) i_overflow_clear <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1 `CHK("ovf_clear", 1'b0, o_overflow)
		stall = 1'b0;
		drain;
		$display("test overflow done");
		fork
			begin
				tb = 8'($random(seed));
				@(posedge i_clk);
				i_tx_data <= tb;
				i_tx_valid <= 1'b1;
				@(posedge i_clk);
				i_tx_valid <= 1'b0;
				for (n2 = 0; n2 < 20 && o_ser_to_camera !== 1'b0; n2++) @(negedge i_clk);
				repeat (1041) @(negedge i_clk);
				`CHK("start_bit", 1'b0, o_ser_to_camera)
				for (n2 = 0; n2 < 8; n2++) begin
					repeat (2083) @(negedge i_clk);
					got[n2] = o_ser_to_camera;
				end
				repeat (2083) @(negedge i_clk);
				`CHK("tx_byte", tb, got)
				`CHK("stop_bit", 1'b1, o_ser_to_camera)
			end
			for (m = 0; m < 2; m++) begin
				rb = 8'($random(seed));
				#7 cam.send_byte(rb, !m[0]);
				`CHK("rx_count", m + 1, rx_cnt)
				`CHK("rx_byte", rb, rx_seen)
				`CHK("rx_frame_err", m[0], err_seen)
			end
		join
		$display("test serial done");
		complete_run;
	end
endmodule // testbench
